// ### design/sms_pkg.sv
// package: types for the standby mode selector
package sms_pkg;
  typedef enum logic [1:0] {
    SMS_NORMAL,
    SMS_HALT,
    SMS_STOP,
    SMS_SNOOZE
  } sms_mode_t;
endpackage

// ### design/sms_map.svh
// constants for the standby mode selector
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_SEL_HALT      3'b100
`define SMS_SEL_STOP      3'b010
`define SMS_SEL_SNOOZE    3'b001
`define SMS_WAKE_THRESH   200
`define SMS_RESULT_W      10
`define SMS_CLK_SETTLE_NS 1000
`define SMS_CLK_PERIOD_NS 20
`define SMS_SETTLE_CYC    ((`SMS_CLK_SETTLE_NS + `SMS_CLK_PERIOD_NS - 1) / `SMS_CLK_PERIOD_NS)
`endif

// ### design/sms_if.sv
// interface between mode controller and clock settle timer
`timescale 1ns/1ns
interface sms_settle_if;
  logic start;
  logic busy;
  modport ctrl  (output start, input busy);
  modport timer (input start, output busy);
endinterface

// ### design/sms_settle.sv
// clock settle timer: holds busy for a fixed settle time after start
`timescale 1ns/1ns
`include "sms_map.svh"
module sms_settle #(
  parameter int CYC = `SMS_SETTLE_CYC
) (
  input  wire logic   core_clk_i, // system clock
  input  wire logic   nrst_i,     // sync reset, active low
  sms_settle_if.timer st          // start and busy
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (st.start) begin
      next_cnt = 16'(CYC);
    end else if (cnt != 16'h0) begin
      next_cnt = cnt - 16'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt <= 16'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign st.busy = (cnt != 16'h0);
endmodule

// ### design/sms_top.sv
// standby mode selector: entry, wake-up and lamp control
`timescale 1ns/1ns
`include "sms_map.svh"
module sms_top
  import sms_pkg::*;
#(
  parameter int RES_W = `SMS_RESULT_W
) (
  input  wire logic             core_clk_i,               // system clock
  input  wire logic             nrst_i,                   // sync reset, active low
  input  wire logic             button_edge_interrupt_i,  // one-cycle button pulse
  input  wire logic             mode_select_in0_i,        // select bit, first
  input  wire logic             mode_select_in1_i,        // select bit, second
  input  wire logic             mode_select_in2_i,        // select bit, third
  input  wire logic             rtc_periodic_interrupt_i, // periodic rtc pulse
  input  wire logic             adc_done_i,               // conversion result valid
  input  wire logic [RES_W-1:0] adc_result_i,             // conversion result
  input  wire logic             clk_switch_req_i,         // clock source change pulse
  input  wire logic             demo_lamp_a_req_i,        // demo lamp a request
  input  wire logic             demo_lamp_b_req_i,        // demo lamp b request
  input  wire logic             demo_lamp_c_req_i,        // demo lamp c request
  output logic                  adc_start_o,              // conversion start pulse
  output logic                  wake_irq_o,               // threshold wake pulse
  output logic                  cpu_stop_o,               // processor clock stopped
  output logic                  demo_run_o,               // demo functions enabled
  output logic                  clk_ready_o,              // clock settled, usable
  output logic                  run_indicator_lamp_o,     // run lamp
  output logic                  demo_lamp_a_o,            // lamp a
  output logic                  demo_lamp_b_o,            // lamp b
  output logic                  demo_lamp_c_o,            // lamp c
  output sms_pkg::sms_mode_t    mode_o                    // current mode
);
  import sms_pkg::*;

  // ==========================================================
  // decode helpers

  // refused patterns map to normal, so a refusal leaves the mode alone
  function automatic sms_mode_t decode_select(logic [2:0] pattern);
    sms_mode_t m;
    m = SMS_NORMAL;
    unique case (pattern)
      `SMS_SEL_HALT:   m = SMS_HALT;
      `SMS_SEL_STOP:   m = SMS_STOP;
      `SMS_SEL_SNOOZE: m = SMS_SNOOZE;
      default:         m = SMS_NORMAL;
    endcase
    return m;
  endfunction

  // halt keeps the processor clock; stop and snooze gate it
  function automatic logic stops_cpu(sms_mode_t m);
    logic s;
    s = 1'b0;
    unique case (m)
      SMS_STOP, SMS_SNOOZE: s = 1'b1;
      SMS_NORMAL, SMS_HALT: s = 1'b0;
    endcase
    return s;
  endfunction

  function automatic logic is_normal(sms_mode_t m);
    return m == SMS_NORMAL;
  endfunction

  // a demo lamp may only light while the block runs normally
  function automatic logic gate_lamp(logic run, logic req);
    return run && req;
  endfunction

  // ==========================================================
  // clock settle

  // every switch request restarts the wait; requests are not queued
  sms_settle_if st ();

  sms_settle u_settle (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .st         (st)
  );
  assign st.start = clk_switch_req_i;

  // ==========================================================
  // mode state

  sms_mode_t  mode;
  sms_mode_t  next_mode;
  logic       cpu_stop;
  logic       next_cpu_stop;
  logic       demo_run;
  logic       next_demo_run;
  logic [2:0] sel;
  logic       hit;

  assign sel = {mode_select_in0_i, mode_select_in1_i, mode_select_in2_i};
  // unsigned compare at the full result width
  assign hit = adc_done_i && (adc_result_i >= RES_W'(`SMS_WAKE_THRESH));

  // status levels come from next_mode so they track mode_o exactly
  always_comb begin
    next_mode = mode;
    unique case (mode)
      SMS_NORMAL: begin
        // a press while the new clock settles is dropped, not deferred
        if (button_edge_interrupt_i && !st.busy) begin
          next_mode = decode_select(sel);
        end
      end
      SMS_HALT, SMS_STOP: begin
        // the select pattern plays no part on the way out
        if (button_edge_interrupt_i) begin
          next_mode = SMS_NORMAL;
        end
      end
      SMS_SNOOZE: begin
        // button ignored here; only the converter wakes snooze
        if (hit) begin
          next_mode = SMS_NORMAL;
        end
      end
    endcase
    next_cpu_stop = stops_cpu(next_mode);
    next_demo_run = is_normal(next_mode);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode     <= SMS_NORMAL;
      cpu_stop <= 1'b0;
      demo_run <= 1'b1;
    end else begin
      mode     <= next_mode;
      cpu_stop <= next_cpu_stop;
      demo_run <= next_demo_run;
    end
  end

  // ==========================================================
  // converter control

  // conversion start and wake are one-cycle registered pulses
  logic adc_start;
  logic next_adc_start;
  logic wake;
  logic next_wake;

  // a tick that meets a hit still starts a conversion; its result goes unused
  always_comb begin
    next_adc_start = 1'b0;
    next_wake      = 1'b0;
    if (mode == SMS_SNOOZE) begin
      next_adc_start = rtc_periodic_interrupt_i;
      next_wake      = hit;
    end
  end

  // wake pulse and the return to normal share one edge
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      adc_start <= 1'b0;
      wake      <= 1'b0;
    end else begin
      adc_start <= next_adc_start;
      wake      <= next_wake;
    end
  end

  // ==========================================================
  // lamps

  // lamps follow mode one cycle later, as registered outputs
  logic normal;
  assign normal = is_normal(mode);

  logic next_run;
  logic next_la;
  logic next_lb;
  logic next_lc;

  always_comb begin
    next_run = normal;
    next_la  = gate_lamp(normal, demo_lamp_a_req_i);
    next_lb  = gate_lamp(normal, demo_lamp_b_req_i);
    next_lc  = gate_lamp(normal, demo_lamp_c_req_i);
  end

  // all lamps dark in reset; run lamp lights one edge after release
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      run_indicator_lamp_o <= 1'b0;
      demo_lamp_a_o        <= 1'b0;
      demo_lamp_b_o        <= 1'b0;
      demo_lamp_c_o        <= 1'b0;
    end else begin
      run_indicator_lamp_o <= next_run;
      demo_lamp_a_o        <= next_la;
      demo_lamp_b_o        <= next_lb;
      demo_lamp_c_o        <= next_lc;
    end
  end

  // ==========================================================
  // outputs

  // clk_ready comes straight from the settle counter register
  assign adc_start_o = adc_start;
  assign wake_irq_o  = wake;
  assign cpu_stop_o  = cpu_stop;
  assign demo_run_o  = demo_run;
  assign clk_ready_o = !st.busy;
  assign mode_o      = mode;
endmodule

// ### bench/sms_adc_model.sv
// converter model answering each conversion start
`timescale 1ns/1ns
module sms_adc_model (
  input  wire logic       core_clk_i, // system clock
  input  wire logic       start_i,    // conversion start pulse
  input  wire logic [9:0] level_i,    // analog level to convert
  output logic            done_o,     // result valid pulse
  output logic      [9:0] result_o    // result, scrambled while not valid
);
  logic [2:0] cnt = 3'h0;
  logic [9:0] last = 10'h0;
  initial done_o = 1'b0;
  // fixed conversion time of three cycles after the start is seen
  always @(posedge core_clk_i) begin
    cnt <= start_i ? 3'h3 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    done_o <= cnt == 3'h1;
    if (cnt == 3'h1) last <= level_i;
  end
  // stale result is inverted so a late sample cannot pass by luck
  assign result_o = done_o ? last : ~last;
endmodule

// ### bench/sms_top_monitor.sv
// port assertions of the standby mode selector
`timescale 1ns/1ns
module sms_top_monitor
  import sms_pkg::*;
(
  input wire logic core_clk_i, nrst_i, button_edge_interrupt_i,     // clock, reset, button
  input wire logic mode_select_in0_i, mode_select_in1_i, mode_select_in2_i, // select
  input wire logic rtc_periodic_interrupt_i, adc_done_i, clk_ready_o, // events
  input wire logic [9:0] adc_result_i,                               // result
  input wire logic adc_start_o, wake_irq_o, cpu_stop_o, demo_run_o,  // outputs
  input wire logic run_indicator_lamp_o, demo_lamp_a_o, demo_lamp_b_o, demo_lamp_c_o, // lamps
  input sms_pkg::sms_mode_t mode_o                                   // mode
);
  wire [2:0] sel = {mode_select_in0_i, mode_select_in1_i, mode_select_in2_i};
  wire take = button_edge_interrupt_i && clk_ready_o && mode_o == SMS_NORMAL;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  halt_entry_a: assert property (take && sel == 3'h4 |=> mode_o == SMS_HALT)
    else $error("halt entry missed");
  stop_entry_a: assert property (take && sel == 3'h2 |=> mode_o == SMS_STOP)
    else $error("stop entry missed");
  snooze_entry_a: assert property (take && sel == 3'h1 |=> mode_o == SMS_SNOOZE)
    else $error("snooze entry missed");
  bad_select_a: assert property (take && !(sel inside {3'h4, 3'h2, 3'h1}) |=>
    mode_o == SMS_NORMAL) else $error("invalid select accepted");
  halt_stop_exit_a: assert property (mode_o inside {SMS_HALT, SMS_STOP} |=>
    mode_o == ($past(button_edge_interrupt_i) ? SMS_NORMAL : $past(mode_o)))
    else $error("halt or stop exit wrong");
  rtc_start_a: assert property (mode_o == SMS_SNOOZE && rtc_periodic_interrupt_i
    |=> adc_start_o && (cpu_stop_o || wake_irq_o)) else $error("conversion not started");
  wake_hit_a: assert property (mode_o == SMS_SNOOZE && adc_done_i &&
    adc_result_i >= 10'h0C8 |=> wake_irq_o && mode_o == SMS_NORMAL) else $error("no wake");
  run_lamp_a: assert property (mode_o != SMS_NORMAL |=> !run_indicator_lamp_o)
    else $error("run lamp on in standby");
  lamps_off_a: assert property (mode_o != SMS_NORMAL |-> !demo_run_o ##1
    !(demo_lamp_a_o || demo_lamp_b_o || demo_lamp_c_o)) else $error("demo not halted");
endmodule
bind sms_top sms_top_monitor u_mon (.*);

// ### bench/sms_top_test.sv
// self-checking testbench of the standby mode selector
`timescale 1ns/1ns
`include "sms_map.svh"
module sms_top_test;
  import sms_pkg::*;
  logic clk = 0, rst_n = 0, btn = 0, rtc = 0, csw = 0, done, start, irq, stp, drun, rdy, run;
  logic [2:0] sel = 3'h0, lreq = 3'h0;
  wire  [2:0] lamp;
  logic [9:0] lvl = 10'h0, res;
  sms_mode_t mode, e;
  int fail_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  // no address bus here, so no reserved location can be reached
  sms_top DUT (.core_clk_i(clk), .nrst_i(rst_n), .button_edge_interrupt_i(btn),
    .mode_select_in0_i(sel[2]), .mode_select_in1_i(sel[1]), .mode_select_in2_i(sel[0]),
    .rtc_periodic_interrupt_i(rtc), .adc_done_i(done), .adc_result_i(res),
    .clk_switch_req_i(csw), .demo_lamp_a_req_i(lreq[0]), .demo_lamp_b_req_i(lreq[1]),
    .demo_lamp_c_req_i(lreq[2]), .adc_start_o(start), .wake_irq_o(irq), .cpu_stop_o(stp),
    .demo_run_o(drun), .clk_ready_o(rdy), .run_indicator_lamp_o(run),
    .demo_lamp_a_o(lamp[0]), .demo_lamp_b_o(lamp[1]), .demo_lamp_c_o(lamp[2]), .mode_o(mode));
  sms_adc_model u_adc (.core_clk_i(clk), .start_i(start), .level_i(lvl), .done_o(done),
    .result_o(res));
  // ==========
  // helpers
  function automatic sms_mode_t exp_mode(logic [2:0] s);
    return s == 3'h4 ? SMS_HALT : s == 3'h2 ? SMS_STOP : s == 3'h1 ? SMS_SNOOZE : SMS_NORMAL;
  endfunction
  task automatic chk(logic [2:0] got, logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic press;
    btn = 1'b1;
    @(negedge clk);
    btn = 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    #400000;
    fail_count++;
    conclude;
  end
  initial begin
    void'($urandom(32'hFF9C8B5A));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(rdy, 3'h1);
    csw = 1'b1;
    @(negedge clk);
    csw = 1'b0;
    chk(rdy, 3'h0);
    sel = 3'h4;
    press;
    chk(mode, SMS_NORMAL);
    repeat (`SMS_SETTLE_CYC - 2) @(negedge clk);
    chk(rdy, 3'h0);
    @(negedge clk);
    chk(rdy, 3'h1);
    $display("test settle done");
    for (int i = 0; i < 40; i++) begin
      sel = i < 8 ? i[2:0] : 3'($urandom);
      lreq = 3'($urandom);
      e = exp_mode(sel);
      press;
      chk(mode, e);
      chk(drun, e == SMS_NORMAL);
      chk(stp, e inside {SMS_STOP, SMS_SNOOZE});
      @(negedge clk);
      chk(run, e == SMS_NORMAL);
      chk(lamp, e == SMS_NORMAL ? lreq : 3'h0);
      if (e == SMS_SNOOZE) begin
        press;
        chk(mode, SMS_SNOOZE);
        for (int k = 0; k < 4 && mode == SMS_SNOOZE; k++) begin
          lvl = k == 3 ? 10'h0C8 : (k == 2 ? 10'h0C7 : 10'($urandom_range(0, 399)));
          rtc = 1'b1;
          @(negedge clk);
          rtc = 1'b0;
          chk(start, 3'h1);
          repeat (5) @(negedge clk);
          chk(mode, lvl >= 10'h0C8 ? SMS_NORMAL : SMS_SNOOZE);
          chk(irq, lvl >= 10'h0C8);
        end
      end else if (e != SMS_NORMAL) begin
        repeat ($urandom_range(1, 6)) @(negedge clk);
        chk(mode, e);
        press;
        chk(mode, SMS_NORMAL);
        chk(drun, 3'h1);
      end
      @(negedge clk);
      $display("test %0d done, select %0h", i, sel);
    end
    conclude;
  end
endmodule
